// File: rtl/cfg_switch_pkg.sv
// Constants and carrier types for the configuration switch control register.
// Assumes one byte clock and a synchronous host control bus on that clock.
package cfg_switch_pkg;

	// Register map and field layout
	localparam logic [7:0] CFG_SWITCH_CTRL_ADDR = 8'h01;
	localparam logic [7:0] CFG_RESET_VALUE      = 8'h00;
	localparam int         A_SEL_LSB            = 0;
	localparam int         B_SEL_LSB            = 2;
	localparam int         TX_SEL_LSB           = 4;
	localparam int         A_EN_BIT             = 6;
	localparam int         B_EN_BIT             = 7;

	// Bus codes of the switch selectors
	localparam logic [1:0] SEL_PHY_INVALID = 2'h0;
	localparam logic [1:0] SEL_RECEIVER    = 2'h1;
	localparam logic [1:0] SEL_A_REQUEST   = 2'h2;
	localparam logic [1:0] SEL_B_REQUEST   = 2'h3;

	// Transmit mode code for active transmit
	localparam logic [2:0] TX_MODE_ACTIVE = 3'h0;

	// Repeat filter symbol pairs and halt limit
	localparam logic [7:0] HALT_PAIR      = 8'h11;
	localparam logic [7:0] IDLE_PAIR      = 8'hFF;
	localparam logic [2:0] MAX_HALT_PAIRS = 3'h4;

	// One switch byte: parity, control flag and eight data bits
	typedef struct packed {
		logic       parity;
		logic       control;
		logic [7:0] data;
	} sw_byte_t;

	typedef enum logic [1:0] {
		RF_PASS   = 2'b00,
		RF_HALTS  = 2'b01,
		RF_IDLE   = 2'b10
	} rf_state_t;

endpackage

// File: rtl/cfg_bus_mux.sv
// Four-to-one selector of configuration switch byte buses.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module cfg_bus_mux (
	input  wire logic [1:0]               sel,
	input  wire cfg_switch_pkg::sw_byte_t phy_invalid,
	input  wire cfg_switch_pkg::sw_byte_t receiver,
	input  wire cfg_switch_pkg::sw_byte_t a_request,
	input  wire cfg_switch_pkg::sw_byte_t b_request,
	output var  cfg_switch_pkg::sw_byte_t picked
);
	import cfg_switch_pkg::*;

	// Encoding shared by all three selectors
	always_comb begin
		unique case (sel)
			SEL_PHY_INVALID: picked = phy_invalid;
			SEL_RECEIVER:    picked = receiver;
			SEL_A_REQUEST:   picked = a_request;
			SEL_B_REQUEST:   picked = b_request;
		endcase
	end
endmodule
`default_nettype wire

// File: rtl/cfg_switch_ctrl.sv
// Configuration switch control register with its switch outputs.
// Assumes the control bus, switch buses and timer reload share SYS_CLK.
//
// Operation
// - A output port carries the bus picked by selector bits 1:0.
// - B output port carries the bus picked by selector bits 3:2.
// - Transmitter input carries the bus picked by selector bits 5:4.
// - A port pins float when A enable is 0, driven when 1.
// - B port pins float when B enable is 0, driven when 1.
// - Active transmit from invalid bus in repeat state: at most four halt pairs, then idle.
// - Host writes are conditional; timer reload may load the register.
// - Without a B port, B bits stay read/write but move no pin.
// - A bit changed since the last host read or write is kept; inhibit flag set.
`timescale 1ns/100ps
`default_nettype none
module cfg_switch_ctrl #(
	parameter bit HAS_B_PORT = 1'b1
) (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RST,
	input  wire logic                     CB_WR,
	input  wire logic                     CB_RD,
	input  wire logic [7:0]               CB_ADDR,
	input  wire logic [7:0]               CB_WDATA,
	output var  logic [7:0]               CB_RDATA,
	input  wire logic                     RELOAD_ENABLE,
	input  wire logic                     RELOAD_STROBE,
	input  wire logic [7:0]               RELOAD_VALUE,
	input  wire logic                     CWI_CLEAR,
	output var  logic                     CWI_FLAG,
	input  wire logic [2:0]               TRANSMIT_MODE,
	input  wire logic                     REPEAT_STATE,
	input  wire cfg_switch_pkg::sw_byte_t PHY_INVALID_BUS,
	input  wire cfg_switch_pkg::sw_byte_t RECEIVER_BUS,
	input  wire cfg_switch_pkg::sw_byte_t A_REQUEST_BUS,
	input  wire cfg_switch_pkg::sw_byte_t B_REQUEST_BUS,
	output var  cfg_switch_pkg::sw_byte_t A_OUT,
	output var  logic                     A_OUT_OE,
	output var  cfg_switch_pkg::sw_byte_t B_OUT,
	output var  logic                     B_OUT_OE,
	output var  cfg_switch_pkg::sw_byte_t TX_IN
);
	import cfg_switch_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register and conditional write

	logic [7:0] cfg_q;
	logic [7:0] snap_q;
	logic [7:0] cfg_d;
	logic [7:0] changed;
	logic       hit_wr;
	logic       hit_rd;
	logic       inhibit;
	logic       cwi_q;

	assign hit_wr  = CB_WR && (CB_ADDR == CFG_SWITCH_CTRL_ADDR);
	assign hit_rd  = CB_RD && (CB_ADDR == CFG_SWITCH_CTRL_ADDR);
	assign changed = cfg_q ^ snap_q;

	// Changed bits keep their value so a reload is never overwritten blindly
	always_comb begin
		cfg_d   = cfg_q;
		inhibit = 1'b0;
		if (RELOAD_ENABLE && RELOAD_STROBE) begin
			cfg_d   = RELOAD_VALUE;
			inhibit = hit_wr;
		end else if (hit_wr) begin
			cfg_d   = (CB_WDATA & ~changed) | (cfg_q & changed);
			inhibit = |changed;
		end
	end

	// Register store
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cfg_q <= CFG_RESET_VALUE;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Compare copy taken at each host read; a write also refreshes it
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			snap_q <= CFG_RESET_VALUE;
		end else if (hit_rd) begin
			snap_q <= cfg_q;
		end else if (hit_wr) begin
			snap_q <= cfg_d;
		end
	end

	// Sticky inhibit flag; a new event beats a clear in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cwi_q <= 1'b0;
		end else if (inhibit) begin
			cwi_q <= 1'b1;
		end else if (CWI_CLEAR) begin
			cwi_q <= 1'b0;
		end
	end
	assign CWI_FLAG = cwi_q;

	// Read data, unmapped addresses answer zero
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CB_RDATA <= 8'h00;
		end else if (CB_RD) begin
			CB_RDATA <= hit_rd ? cfg_q : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switch selection

	logic [1:0] sel [3];
	sw_byte_t   pick [3];

	assign sel[0] = cfg_q[A_SEL_LSB +: 2];
	assign sel[1] = cfg_q[B_SEL_LSB +: 2];
	assign sel[2] = cfg_q[TX_SEL_LSB +: 2];

	// One selector per destination: A port, B port, transmitter
	for (genvar i = 0; i < 3; i++) begin : g_mux
		cfg_bus_mux u_mux (
			.sel         (sel[i]),
			.phy_invalid (PHY_INVALID_BUS),
			.receiver    (RECEIVER_BUS),
			.a_request   (A_REQUEST_BUS),
			.b_request   (B_REQUEST_BUS),
			.picked      (pick[i])
		);
	end

	// Outputs are registered so data and enable switch together
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			A_OUT    <= '0;
			A_OUT_OE <= 1'b0;
		end else begin
			A_OUT    <= pick[0];
			A_OUT_OE <= cfg_q[A_EN_BIT];
		end
	end

	// Without a B port the bits remain stored but the pins never drive
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			B_OUT    <= '0;
			B_OUT_OE <= 1'b0;
		end else begin
			B_OUT    <= HAS_B_PORT ? pick[1] : '0;
			B_OUT_OE <= HAS_B_PORT && cfg_q[B_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Repeat filter on the transmit path

	rf_state_t  rf_q;
	logic [2:0] halts_q;
	logic       filt_on;

	assign filt_on = (TRANSMIT_MODE == TX_MODE_ACTIVE) && REPEAT_STATE
		&& (sel[2] == SEL_PHY_INVALID);

	// Counts halt pairs passed; once the limit is met only idle leaves
	always_ff @(posedge SYS_CLK) begin
		if (RST || !filt_on) begin
			rf_q    <= RF_PASS;
			halts_q <= 3'h0;
		end else begin
			unique case (rf_q)
				RF_PASS, RF_HALTS: begin
					if (pick[2].data == HALT_PAIR) begin
						halts_q <= halts_q + 3'h1;
						rf_q    <= (halts_q + 3'h1 == MAX_HALT_PAIRS) ? RF_IDLE : RF_HALTS;
					end
				end
				RF_IDLE: rf_q <= RF_IDLE;
				default: rf_q <= RF_PASS;
			endcase
		end
	end

	// Transmitter input; idle replaces anything once halts are spent
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			TX_IN <= '0;
		end else if (filt_on && (rf_q == RF_IDLE || pick[2].data != HALT_PAIR)) begin
			TX_IN <= '{parity: ~^IDLE_PAIR, control: 1'b0, data: IDLE_PAIR};
		end else begin
			TX_IN <= pick[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_a_follow;
		sel[0] == SEL_RECEIVER |=> A_OUT == $past(RECEIVER_BUS);
	endproperty
	a_a_follow: assert property (p_a_follow) else $error("A port not receiver");

	property p_b_follow;
		HAS_B_PORT && sel[1] == SEL_A_REQUEST |=> B_OUT == $past(A_REQUEST_BUS);
	endproperty
	a_b_follow: assert property (p_b_follow) else $error("B port wrong bus");

	property p_tx_follow;
		sel[2] == SEL_B_REQUEST |=> TX_IN == $past(B_REQUEST_BUS);
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("TX input wrong bus");

	property p_a_enable;
		##1 A_OUT_OE == $past(cfg_q[A_EN_BIT]);
	endproperty
	a_a_enable: assert property (p_a_enable) else $error("A enable mismatch");

	property p_b_enable;
		!cfg_q[B_EN_BIT] |=> !B_OUT_OE;
	endproperty
	a_b_enable: assert property (p_b_enable) else $error("B driven while off");

	property p_halt_limit;
		filt_on && rf_q == RF_IDLE |=> TX_IN.data == IDLE_PAIR;
	endproperty
	a_halt_limit: assert property (p_halt_limit) else $error("Halt after limit");

	property p_clean_write;
		hit_wr && !RELOAD_STROBE && changed == 8'h00 |=> cfg_q == $past(CB_WDATA);
	endproperty
	a_clean_write: assert property (p_clean_write) else $error("Write lost");

	property p_inhibit;
		hit_wr && !RELOAD_STROBE && changed != 8'h00 |=> CWI_FLAG
			&& (cfg_q & $past(changed)) == ($past(cfg_q) & $past(changed));
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("Changed bit overwritten");

	property p_no_b_port;
		!HAS_B_PORT |-> !B_OUT_OE && B_OUT == '0;
	endproperty
	a_no_b_port: assert property (p_no_b_port) else $error("B pin moved");

	property p_reload;
		RELOAD_ENABLE && RELOAD_STROBE |=> cfg_q == $past(RELOAD_VALUE);
	endproperty
	a_reload: assert property (p_reload) else $error("Reload missed");

	c_inhibit: cover property (hit_wr && changed != 8'h00);
	c_reload:  cover property (RELOAD_ENABLE && RELOAD_STROBE);
	c_halted:  cover property (filt_on && rf_q == RF_IDLE);
	c_a_on:    cover property (A_OUT_OE && $rose(A_OUT_OE));
endmodule
`default_nettype wire

// File: tb/src_model.sv
// Model of the four switch byte sources feeding the switch.
// Assumes the design samples them on the rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module src_model (
	input  wire logic                     clk,
	input  wire logic                     halt_mode,
	output var  cfg_switch_pkg::sw_byte_t bus [4]
);
	import cfg_switch_pkg::*;
	logic [5:0] cnt_q = 6'h00;
	logic [7:0] d;
	////////////////////////////////////////////////////////////////////////
	// Fresh value each cycle, so a stale or wrong pick cannot pass
	always @(negedge clk) begin
		cnt_q <= cnt_q + 6'h01;
		for (int i = 0; i < 4; i++) begin
			d = (halt_mode && i == 0) ? HALT_PAIR : {2'(i), cnt_q};
			bus[i] <= {~^d, i[0], d};
		end
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the configuration switch control register.
// Assumes the source model drives the switch buses and the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cfg_switch_pkg::*;
	logic       SYS_CLK = 1'b0, RST = 1'b1, CB_WR = 1'b0, CB_RD = 1'b0, halt_mode = 1'b0;
	logic [7:0] CB_ADDR = 8'h00, CB_WDATA = 8'h00, RELOAD_VALUE = 8'h00, CB_RDATA, v, e;
	logic       RELOAD_ENABLE = 1'b0, RELOAD_STROBE = 1'b0, CWI_CLEAR = 1'b0, REPEAT_STATE = 1'b0;
	logic [2:0] TRANSMIT_MODE = 3'h1;
	logic       CWI_FLAG, A_OUT_OE, B_OUT_OE;
	sw_byte_t   A_OUT, B_OUT, TX_IN, idle, nb_b_out;
	logic [7:0] nb_rdata;
	logic       nb_b_oe;
	sw_byte_t   bus [4];
	sw_byte_t   prev [4];
	int         failures = 0, checked = 0, n;

	always #12.5 SYS_CLK = ~SYS_CLK;
	// Bus values as the design saw them at the last edge
	always @(posedge SYS_CLK) prev <= bus;

	src_model src_u (.clk(SYS_CLK), .halt_mode(halt_mode), .bus(bus));
	cfg_switch_ctrl dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .CB_WR(CB_WR), .CB_RD(CB_RD),
		.CB_ADDR(CB_ADDR), .CB_WDATA(CB_WDATA), .CB_RDATA(CB_RDATA),
		.RELOAD_ENABLE(RELOAD_ENABLE), .RELOAD_STROBE(RELOAD_STROBE),
		.RELOAD_VALUE(RELOAD_VALUE), .CWI_CLEAR(CWI_CLEAR), .CWI_FLAG(CWI_FLAG),
		.TRANSMIT_MODE(TRANSMIT_MODE), .REPEAT_STATE(REPEAT_STATE),
		.PHY_INVALID_BUS(bus[0]), .RECEIVER_BUS(bus[1]), .A_REQUEST_BUS(bus[2]),
		.B_REQUEST_BUS(bus[3]), .A_OUT(A_OUT), .A_OUT_OE(A_OUT_OE), .B_OUT(B_OUT),
		.B_OUT_OE(B_OUT_OE), .TX_IN(TX_IN));
	// Variant without a B port, fed the same stimulus so its pins can be held to zero
	cfg_switch_ctrl #(.HAS_B_PORT(1'b0)) dut_nb_u (.SYS_CLK(SYS_CLK), .RST(RST), .CB_WR(CB_WR),
		.CB_RD(CB_RD), .CB_ADDR(CB_ADDR), .CB_WDATA(CB_WDATA), .CB_RDATA(nb_rdata),
		.RELOAD_ENABLE(RELOAD_ENABLE), .RELOAD_STROBE(RELOAD_STROBE),
		.RELOAD_VALUE(RELOAD_VALUE), .CWI_CLEAR(CWI_CLEAR), .CWI_FLAG(),
		.TRANSMIT_MODE(TRANSMIT_MODE), .REPEAT_STATE(REPEAT_STATE),
		.PHY_INVALID_BUS(bus[0]), .RECEIVER_BUS(bus[1]), .A_REQUEST_BUS(bus[2]),
		.B_REQUEST_BUS(bus[3]), .A_OUT(), .A_OUT_OE(), .B_OUT(nb_b_out),
		.B_OUT_OE(nb_b_oe), .TX_IN());

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One host cycle; strobe lasts exactly one edge
	task automatic cb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge SYS_CLK);
		CB_WR = wr;
		CB_RD = !wr;
		CB_ADDR = a;
		CB_WDATA = d;
		@(negedge SYS_CLK);
		CB_WR = 1'b0;
		CB_RD = 1'b0;
	endtask
	// Read first so every bit is writable, then let outputs follow
	task automatic put(input logic [7:0] d);
		cb(1'b0, CFG_SWITCH_CTRL_ADDR, 8'h00);
		cb(1'b1, CFG_SWITCH_CTRL_ADDR, d);
		repeat (2) @(negedge SYS_CLK);
	endtask
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("a_oe", A_OUT_OE, 1'b0);
		chk("b_oe", B_OUT_OE, 1'b0);
		cb(1'b0, CFG_SWITCH_CTRL_ADDR, 8'h00);
		chk("reset value", CB_RDATA, CFG_RESET_VALUE);
		$display("test reset done");
	endtask
	task automatic t_select;
		for (int s = 0; s < 4; s++) begin
			put({2'b11, 2'(s), 2'(s), 2'(s)});
			chk("a_out", A_OUT, prev[s]);
			chk("b_out", B_OUT, prev[s]);
			chk("tx_in", TX_IN, prev[s]);
			@(negedge SYS_CLK);
			chk("a_out next", A_OUT, prev[s]);
		end
		put(8'hC6);
		chk("a_out mix", A_OUT, prev[2]);
		chk("b_out mix", B_OUT, prev[1]);
		chk("tx_in mix", TX_IN, prev[0]);
		$display("test select done");
	endtask
	task automatic t_enable;
		for (int k = 0; k < 4; k++) begin
			v = {2'(k), 6'h00};
			put(v);
			chk("a_oe", A_OUT_OE, v[A_EN_BIT]);
			chk("b_oe", B_OUT_OE, v[B_EN_BIT]);
		end
		cb(1'b1, 8'h02, 8'h00);
		cb(1'b0, CFG_SWITCH_CTRL_ADDR, 8'h00);
		chk("unmapped write", CB_RDATA, 8'hC0);
		chk("no-B readback", nb_rdata, 8'hC0);
		chk("no-B b_oe", nb_b_oe, 1'b0);
		chk("no-B b_out", nb_b_out, 10'h000);
		cb(1'b0, 8'h02, 8'h00);
		chk("unmapped read", CB_RDATA, 8'h00);
		$display("test enable done");
	endtask
	// Timer reload between read and write protects the bits it changed
	task automatic t_cond;
		@(negedge SYS_CLK);
		RELOAD_ENABLE = 1'b1;
		RELOAD_VALUE = 8'h5A;
		RELOAD_STROBE = 1'b1;
		@(negedge SYS_CLK);
		RELOAD_STROBE = 1'b0;
		cb(1'b1, CFG_SWITCH_CTRL_ADDR, 8'h0F);
		// Reload changed bits 7, 4, 3 and 1: those keep 5A, the rest take 0F
		e = 8'h1F;
		chk("inhibit set", CWI_FLAG, 1'b1);
		cb(1'b0, CFG_SWITCH_CTRL_ADDR, 8'h00);
		chk("kept bits", CB_RDATA, e);
		CWI_CLEAR = 1'b1;
		@(negedge SYS_CLK);
		CWI_CLEAR = 1'b0;
		chk("inhibit clear", CWI_FLAG, 1'b0);
		RELOAD_ENABLE = 1'b0;
		RELOAD_STROBE = 1'b1;
		@(negedge SYS_CLK);
		RELOAD_STROBE = 1'b0;
		cb(1'b0, CFG_SWITCH_CTRL_ADDR, 8'h00);
		chk("reload off", CB_RDATA, e);
		$display("test conditional done");
	endtask
	// Halt pairs from the invalid bus are cut to four in repeat state, then idle
	task automatic t_filter;
		put(8'h00);
		halt_mode = 1'b1;
		TRANSMIT_MODE = TX_MODE_ACTIVE;
		repeat (3) @(negedge SYS_CLK);
		chk("halt passes", TX_IN.data, HALT_PAIR);
		REPEAT_STATE = 1'b1;
		n = 0;
		repeat (10) begin
			@(negedge SYS_CLK);
			n += int'(TX_IN.data === HALT_PAIR);
		end
		idle = {~^IDLE_PAIR, 1'b0, IDLE_PAIR};
		chk("halt count", 10'(n), 10'(MAX_HALT_PAIRS));
		chk("idle", TX_IN, idle);
		REPEAT_STATE = 1'b0;
		halt_mode = 1'b0;
		TRANSMIT_MODE = 3'h1;
		$display("test filter done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge SYS_CLK);
		RST = 1'b0;
		t_reset();
		t_select();
		t_enable();
		t_cond();
		t_filter();
		close_out();
	end
	// Cuts a hang well past the expected run of about a hundred cycles
	initial begin
		repeat (2000) @(posedge SYS_CLK);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
